// *** hw/mdt_top.sv ***
`timescale 1ns/1ps
module mdt_top #(
   parameter int TIMER_IDX = 1 // Which timer of the group this is
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire mdt_pkg::mdt_mode_t timer_mode_reg_i, // Operating mode
   input wire logic count_start_bit_i, // Count start
   input wire logic up_down_select_reg_i, // Event mode: 1 counts up
   input wire logic trigger_source_reg_i, // 1 selects the input pin as trigger
   input wire logic cnt_src_tick_i, // One-cycle count-source pulse
   input wire logic wr_en_i, // Counter write strobe
   input wire logic [mdt_pkg::CNT_W-1:0] wr_data_i,
   input wire logic rd_en_i, // Counter read strobe
   input wire logic irq_clr_i, // Software clear of the request flag
   input wire logic forced_cutoff_enable_i,
   input wire logic shutdown_input_n_i, // Asynchronous, low forces cutoff
   input wire logic timer_input_pin_i, // Asynchronous event or trigger pin
   output logic [mdt_pkg::CNT_W-1:0] counter_value_reg_o, // Read data
   output logic rd_valid_o, // One cycle after rd_en_i
   output logic interrupt_request_flag_o,
   output logic timer_output_pin_o,
   output logic timer_output_pin_oe_o // High while the pin is driven
);
   import mdt_pkg::*;

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (TIMER_IDX < 0 || TIMER_IDX > 4) begin : g_idx_chk
      $error("TIMER_IDX must lie in 0..4");
   end

   // Only timers 1, 2 and 4 share the forced cutoff
   localparam logic CUT_CAPABLE = (TIMER_IDX == 1) || (TIMER_IDX == 2) || (TIMER_IDX == 4);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [CNT_W-1:0] cnt_reg, cnt_next; // Live counter
   logic [CNT_W-1:0] rel_reg, rel_next; // Reload value
   logic [CNT_W-1:0] rd_reg, rd_next; // Read-back latch
   logic rdv_reg, rdv_next;
   logic out_reg, out_next; // Output level
   logic oe_reg, oe_next; // Output enable
   logic run_reg, run_next; // One-shot or PWM cycle active
   logic pend_reg, pend_next; // Trigger waiting for the next tick
   logic start_d_reg; // Start bit one cycle ago
   mdt_mode_t mode_d_reg; // Mode one cycle ago
   logic stop_irq_reg, stop_irq_next; // Delayed one-shot stop request
   logic set_evt; // Request flag set this cycle
   logic uflow, oflow; // Reload after underflow or overflow
   logic start_fall, start_rise;
   logic trig; // Trigger seen this cycle
   logic sd_level; // Filtered shutdown level
   logic pin_rise; // Filtered rising edge on the input pin
   logic irq_set;

   // ****************************************************************
   // Pin filters and request flag
   // ****************************************************************
   mdt_pin_sync #(.RESET_LEVEL(SHUTDOWN_RESET_LEVEL)) u_sd_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .pin_i(shutdown_input_n_i),
      .level_o(sd_level),
      .rise_o()
   );

   mdt_pin_sync #(.RESET_LEVEL(PIN_RESET_LEVEL)) u_in_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .pin_i(timer_input_pin_i),
      .level_o(),
      .rise_o(pin_rise)
   );

   assign irq_set = set_evt || stop_irq_reg;

   mdt_irq_flag u_irq (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .set_i(irq_set),
      .clr_i(irq_clr_i),
      .flag_o(interrupt_request_flag_o)
   );

   // Edges of the start bit; start_d_reg resets low so a set after reset is a rise
   assign start_fall = start_d_reg && !count_start_bit_i;
   assign start_rise = !start_d_reg && count_start_bit_i;
   // External trigger from the pin, else the start bit itself
   assign trig = trigger_source_reg_i ? pin_rise : start_rise;

   // ****************************************************************
   // Next-state logic of the counter, output and flags
   // ****************************************************************
   always_comb begin
      cnt_next = cnt_reg;
      rel_next = rel_reg;
      out_next = out_reg;
      run_next = run_reg;
      pend_next = pend_reg;
      stop_irq_next = 1'b0;
      set_evt = 1'b0;
      uflow = 1'b0;
      oflow = 1'b0;
      // Writes always reach the reload value; the counter only while stopped
      if (wr_en_i) begin
         rel_next = wr_data_i;
         if (!count_start_bit_i) begin
            cnt_next = wr_data_i;
         end
      end
      case (timer_mode_reg_i)
         MDT_TIMER: begin
            // Nothing moves until the start bit is one
            if (count_start_bit_i && cnt_src_tick_i) begin
               if (cnt_reg == CNT_ALL_ZEROS) begin
                  cnt_next = rel_reg;
                  uflow = 1'b1;
                  set_evt = 1'b1;
               end else begin
                  cnt_next = cnt_reg - 16'h0001;
               end
            end
         end
         MDT_EVENT: begin
            // Direction select is assumed steady while counting
            if (count_start_bit_i && pin_rise) begin
               if (up_down_select_reg_i) begin
                  if (cnt_reg == CNT_ALL_ONES) begin
                     cnt_next = rel_reg;
                     oflow = 1'b1;
                     set_evt = 1'b1;
                  end else begin
                     cnt_next = cnt_reg + 16'h0001;
                  end
               end else if (cnt_reg == CNT_ALL_ZEROS) begin
                  cnt_next = rel_reg;
                  uflow = 1'b1;
                  set_evt = 1'b1;
               end else begin
                  cnt_next = cnt_reg - 16'h0001;
               end
            end
         end
         MDT_ONESHOT: begin
            // Triggers wait for the count source, so the output is tick aligned
            if (count_start_bit_i && trig) begin
               pend_next = 1'b1;
            end
            if (count_start_bit_i && cnt_src_tick_i) begin
               if (pend_reg) begin
                  // First trigger starts, a later one reloads
                  cnt_next = rel_reg;
                  run_next = 1'b1;
                  out_next = 1'b1;
                  pend_next = trig;
               end else if (run_reg) begin
                  if (cnt_reg == CNT_ALL_ZEROS) begin
                     cnt_next = rel_reg;
                     uflow = 1'b1;
                     run_next = 1'b0;
                     out_next = 1'b0;
                     set_evt = 1'b1;
                  end else begin
                     cnt_next = cnt_reg - 16'h0001;
                  end
               end
            end
            // Stop by software: halt, reload, low, flag one cycle later
            if (start_fall) begin
               run_next = 1'b0;
               pend_next = 1'b0;
               cnt_next = rel_reg;
               out_next = 1'b0;
               stop_irq_next = 1'b1;
            end
         end
         MDT_PWM: begin
            if (count_start_bit_i && trig && !run_reg) begin
               pend_next = 1'b1;
            end
            if (count_start_bit_i && cnt_src_tick_i) begin
               if (pend_reg && !run_reg) begin
                  cnt_next = rel_reg;
                  run_next = 1'b1;
                  out_next = 1'b1;
                  pend_next = 1'b0;
               end else if (run_reg) begin
                  // High for the reload count, low for the rest of the period
                  if (cnt_reg == CNT_ALL_ZEROS) begin
                     out_next = !out_reg;
                     cnt_next = out_reg ? ~rel_reg : rel_reg;
                     uflow = 1'b1;
                     set_evt = out_reg;
                  end else begin
                     cnt_next = cnt_reg - 16'h0001;
                  end
               end
            end
            // Stop: a high level drops and flags, a low level stays quiet
            if (start_fall) begin
               run_next = 1'b0;
               pend_next = 1'b0;
               if (out_reg) begin
                  out_next = 1'b0;
                  set_evt = 1'b1;
               end
            end
         end
         default: begin
            run_next = 1'b0;
         end
      endcase
      // Entering one-shot or PWM from timer or event mode raises the flag
      if ((timer_mode_reg_i == MDT_ONESHOT || timer_mode_reg_i == MDT_PWM) &&
          (mode_d_reg == MDT_TIMER || mode_d_reg == MDT_EVENT)) begin
         set_evt = 1'b1;
      end
   end

   // ****************************************************************
   // Read-back and output stage next values
   // ****************************************************************
   always_comb begin
      rd_next = rd_reg;
      rdv_next = rd_en_i;
      // A read in a reload cycle sees the wrapped value, not the new one
      if (rd_en_i) begin
         if (uflow) begin
            rd_next = CNT_ALL_ONES;
         end else if (oflow) begin
            rd_next = CNT_ALL_ZEROS;
         end else begin
            rd_next = cnt_reg;
         end
      end
      // Forced cutoff floats the pin; the internal level keeps running
      oe_next = !(CUT_CAPABLE && forced_cutoff_enable_i && !sd_level);
   end

   // ****************************************************************
   // State registers
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_reg <= CNT_RESET;
         rel_reg <= CNT_RESET;
         rd_reg <= CNT_RESET;
         rdv_reg <= 1'b0;
         out_reg <= OUT_RESET;
         oe_reg <= OE_RESET;
         run_reg <= 1'b0;
         pend_reg <= 1'b0;
         start_d_reg <= 1'b0;
         mode_d_reg <= MDT_TIMER;
         stop_irq_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         rel_reg <= rel_next;
         rd_reg <= rd_next;
         rdv_reg <= rdv_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
         run_reg <= run_next;
         pend_reg <= pend_next;
         start_d_reg <= count_start_bit_i;
         mode_d_reg <= timer_mode_reg_i;
         stop_irq_reg <= stop_irq_next;
      end
   end

   assign counter_value_reg_o = rd_reg;
   assign rd_valid_o = rdv_reg;
   assign timer_output_pin_o = out_reg;
   assign timer_output_pin_oe_o = oe_reg;

   // ****************************************************************
   // Assertions and covers
   // ****************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   a_idle_no_count: assert property (
      !count_start_bit_i && !start_d_reg && !wr_en_i |=> $stable(cnt_reg))
      else $error("counter moved while stopped");

   a_timer_reload_read: assert property (
      rd_en_i && timer_mode_reg_i == MDT_TIMER && uflow
      |=> rd_valid_o && counter_value_reg_o == 16'hffff)
      else $error("reload read in timer mode not all ones");

   a_event_oflow_read: assert property (
      rd_en_i && timer_mode_reg_i == MDT_EVENT && oflow
      |=> counter_value_reg_o == 16'h0000)
      else $error("overflow read not all zeros");

   a_written_readback: assert property (
      wr_en_i && !count_start_bit_i && !start_d_reg
      ##1 rd_en_i && !wr_en_i && !count_start_bit_i
      |=> counter_value_reg_o == $past(wr_data_i, 2))
      else $error("written value not read back");

   a_cutoff_float: assert property (
      CUT_CAPABLE && forced_cutoff_enable_i && !sd_level |=> !timer_output_pin_oe_o)
      else $error("output driven during cutoff");

   a_oneshot_stop: assert property (
      timer_mode_reg_i == MDT_ONESHOT && start_fall
      |=> !timer_output_pin_o && !run_reg && cnt_reg == $past(rel_reg)
      ##1 interrupt_request_flag_o)
      else $error("one-shot stop sequence wrong");

   a_mode_select_irq: assert property (
      timer_mode_reg_i inside {MDT_ONESHOT, MDT_PWM} &&
      mode_d_reg inside {MDT_TIMER, MDT_EVENT}
      |=> interrupt_request_flag_o)
      else $error("mode selection did not raise flag");

   a_trigger_on_tick: assert property (
      timer_mode_reg_i == MDT_ONESHOT && count_start_bit_i && cnt_src_tick_i && pend_reg
      |=> timer_output_pin_o && cnt_reg == $past(rel_reg))
      else $error("pending trigger not served on tick");

   a_pwm_stop_high: assert property (
      timer_mode_reg_i == MDT_PWM && start_fall && out_reg
      |=> !timer_output_pin_o && interrupt_request_flag_o)
      else $error("PWM stop from high wrong");

   a_timer_decrement: assert property (
      timer_mode_reg_i == MDT_TIMER && count_start_bit_i && cnt_src_tick_i && !wr_en_i &&
      cnt_reg != 16'h0000 |=> cnt_reg == $past(cnt_reg) - 16'h0001)
      else $error("timer mode did not decrement");

   c_oneshot_fire: cover property (
      timer_mode_reg_i == MDT_ONESHOT && run_reg && uflow);
   c_pwm_fall: cover property (
      timer_mode_reg_i == MDT_PWM && out_reg ##1 !out_reg);
   c_event_overflow: cover property (oflow);
   c_cutoff: cover property (!timer_output_pin_oe_o ##1 timer_output_pin_oe_o);
endmodule

// *** hw/mdt_pkg.sv ***
// ****************************************************************
// Shared constants and types of the multimode down timer
// ****************************************************************
package mdt_pkg;

   // Counter width and special read-back values
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
   localparam logic [15:0] CNT_ALL_ZEROS = 16'h0000;
   localparam logic [15:0] CNT_RESET = 16'h0000;

   // Clock period and trigger lead time the trigger source must respect
   localparam int CLK_PERIOD_NS = 8;
   localparam int TRIG_LEAD_NS = 300;
   // Least time, so rounded up to whole cycles
   localparam int TRIG_LEAD_CYC = (TRIG_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Delay from a one-shot stop to the request flag, in CPU cycles
   localparam int STOP_IRQ_DELAY_CYC = 1;

   // Reset values of the pin filters and of the output stage
   localparam logic PIN_RESET_LEVEL = 1'b0;
   localparam logic SHUTDOWN_RESET_LEVEL = 1'b1;
   localparam logic OUT_RESET = 1'b0;
   localparam logic OE_RESET = 1'b0;

   // Operating modes, as held in timer_mode_reg
   typedef enum logic [1:0] {
      MDT_TIMER,
      MDT_EVENT,
      MDT_ONESHOT,
      MDT_PWM
   } mdt_mode_t;

endpackage

// *** hw/mdt_pin_sync.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Three-stage pin filter with agreement check
// ****************************************************************
module mdt_pin_sync #(
   parameter logic RESET_LEVEL = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic pin_i, // Asynchronous pin
   output logic level_o, // Filtered level
   output logic rise_o // One-cycle pulse on a rising change
);
   import mdt_pkg::*;

   logic s1_reg, s2_reg, s3_reg; // Synchroniser chain
   logic level_reg, level_next;
   logic rise_reg, rise_next;

   // Next level: only once the second and third stages agree
   always_comb begin
      level_next = level_reg;
      rise_next = 1'b0;
      if (s2_reg == s3_reg) begin
         level_next = s3_reg;
         rise_next = s3_reg && !level_reg;
      end
   end

   // Registers; first stage is read by the second alone
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s1_reg <= RESET_LEVEL;
         s2_reg <= RESET_LEVEL;
         s3_reg <= RESET_LEVEL;
         level_reg <= RESET_LEVEL;
         rise_reg <= 1'b0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
         rise_reg <= rise_next;
      end
   end

   assign level_o = level_reg;
   assign rise_o = rise_reg;
endmodule

// *** hw/mdt_irq_flag.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Sticky interrupt request flag, set wins over clear
// ****************************************************************
module mdt_irq_flag (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic set_i, // Hardware event
   input wire logic clr_i, // Software clear
   output logic flag_o
);
   import mdt_pkg::*;

   logic flag_reg, flag_next;

   // A set in the clearing cycle is kept, so no event is lost
   always_comb begin
      flag_next = flag_reg;
      if (clr_i) begin
         flag_next = 1'b0;
      end
      if (set_i) begin
         flag_next = 1'b1;
      end
   end

   // Register
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag_o = flag_reg;
endmodule

// *** verification/mdt_far_end.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Far side: trigger and event pin source, shutdown pin source
// ****************************************************************
module mdt_far_end (
   input wire logic ref_clk_i,
   output logic timer_input_pin_o,
   output logic shutdown_input_n_o
);
   // Both pins idle in their quiet level
   initial begin
      timer_input_pin_o = 1'b0;
      shutdown_input_n_o = 1'b1;
   end
   // Edge high for hold cycles, then low as long again; hold must beat
   // the pin filter, and the low tail spaces any retrigger
   task automatic pulse(input int hold);
      @(posedge ref_clk_i);
      #1 timer_input_pin_o = 1'b1;
      repeat (hold) @(posedge ref_clk_i);
      #1 timer_input_pin_o = 1'b0;
      repeat (hold) @(posedge ref_clk_i);
      #1;
   endtask
   // Shutdown level, moved just after an edge
   task automatic set_shutdown(input logic lvl);
      @(posedge ref_clk_i);
      #1 shutdown_input_n_o = lvl;
   endtask
endmodule

// *** verification/tb_multimode_down_timer.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the multimode down timer
// ****************************************************************
module tb_multimode_down_timer;
   import mdt_pkg::*;
   logic clk, srst, start, updn, tsrc, tick, wr_en, rd_en, irq_clr, cut_en;
   mdt_mode_t mode;
   logic [15:0] wr_data, rdata, v;
   logic rvalid, flag, tout, toe, pin, sd_n;
   int n_fail, comparisons, cycles, m_cnt, m_rel, h;
   logic mdl_ok, chk1; // Model compare enable, read taken at last edge
   logic [15:0] e1; // Expected read data of that read
   logic sp_on = 1'b0; // Wrap-value read counting enabled
   int n_sp; // Reads that showed the wrap value
   logic [15:0] e2; // Wrap value of the current event direction
   mdt_top #(.TIMER_IDX(1)) u_mdt_top (.ref_clk_i(clk), .srst_i(srst),
      .timer_mode_reg_i(mode), .count_start_bit_i(start), .up_down_select_reg_i(updn),
      .trigger_source_reg_i(tsrc), .cnt_src_tick_i(tick), .wr_en_i(wr_en),
      .wr_data_i(wr_data), .rd_en_i(rd_en), .irq_clr_i(irq_clr),
      .forced_cutoff_enable_i(cut_en), .shutdown_input_n_i(sd_n),
      .timer_input_pin_i(pin), .counter_value_reg_o(rdata), .rd_valid_o(rvalid),
      .interrupt_request_flag_o(flag), .timer_output_pin_o(tout),
      .timer_output_pin_oe_o(toe));
   mdt_far_end u_mdt_far_end (.ref_clk_i(clk), .timer_input_pin_o(pin),
      .shutdown_input_n_o(sd_n));
   // ****************************************************************
   // Clock, timeout and closing report
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Whole run is well under a thousand cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         $display("MISMATCH at %0t: run timed out", $time);
         close_out();
      end
   end
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // ****************************************************************
   // Timer-mode reference model, checked at every read result while mdl_ok is set
   // ****************************************************************
   // Read data is the count before the edge, or all ones on a reload edge
   always @(posedge clk) begin
      chk1 = rd_en && mdl_ok && !srst;
      e1 = (start && tick && m_cnt == 0) ? CNT_ALL_ONES : m_cnt[15:0];
      if (srst) begin
         m_cnt = 0;
         m_rel = 0;
      end else begin
         if (start && tick && mode == MDT_TIMER) begin
            m_cnt = (m_cnt == 0) ? m_rel : m_cnt - 1;
         end
         if (wr_en && !start) begin
            m_cnt = wr_data;
         end
         if (wr_en) begin
            m_rel = wr_data;
         end
      end
   end
   always @(negedge clk) begin
      if (chk1) begin
         chk({15'h0, rvalid}, 16'h0001, "read valid");
         chk(rdata, e1, "timer read");
      end
   end
   // Event mode: reads in a reload cycle must show the wrap value exactly once
   always @(negedge clk) begin
      if (!sp_on) begin
         n_sp = 0;
      end else if (rvalid && rdata === e2) begin
         n_sp++;
      end
   end
   // ****************************************************************
   // Bus-cycle helpers
   // ****************************************************************
   // Inputs always move 1 ns after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] d);
      wr_en = 1'b1;
      wr_data = d;
      cyc(1);
      wr_en = 1'b0;
   endtask
   // Read strobe for one cycle, answer awaited under a bound
   task automatic rd(output logic [15:0] d);
      int k;
      k = 0;
      rd_en = 1'b1;
      cyc(1);
      rd_en = 1'b0;
      while (rvalid !== 1'b1 && k < 3) begin
         cyc(1);
         k++;
      end
      chk({15'h0, rvalid}, 16'h0001, "read answer");
      d = rdata;
   endtask
   task automatic clr();
      irq_clr = 1'b1;
      cyc(1);
      irq_clr = 1'b0;
      cyc(1);
   endtask
   // Mode moves only while the start bit is low
   task automatic set_mode(input mdt_mode_t m);
      start = 1'b0;
      cyc(1);
      mode = m;
      cyc(2);
   endtask
   task automatic done(input string name);
      $display("test %s done", name);
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {srst, start, updn, tsrc, wr_en, rd_en, irq_clr, cut_en, mdl_ok} = 9'h001 << 8;
      mode = MDT_TIMER;
      tick = 1'b1;
      wr_data = 16'h0000;
      h = $urandom(32'h6c588ff0);
      repeat (20) @(posedge clk);
      #1 srst = 1'b0;
      // Idle after reset: ticks arrive, nothing counts
      cyc(10);
      rd(v);
      chk(v, CNT_RESET, "idle count");
      chk({15'h0, flag}, 16'h0000, "idle flag");
      chk({15'h0, tout}, 16'h0000, "idle out");
      chk({15'h0, toe}, 16'h0001, "idle drive");
      done("idle");
      // Written value reads back before start, ticks running
      for (int i = 0; i < 4; i++) begin
         wr_data = $urandom;
         h = wr_data;
         wr(wr_data);
         // Even passes read in the very next cycle, odd ones after a gap
         if (i[0]) begin
            cyc(3);
         end
         rd(v);
         chk(v, h[15:0], "write then read");
      end
      done("preset");
      // Timer mode with random ticks and reads, small reload for many reloads
      wr($urandom % 6);
      mdl_ok = 1'b1;
      // Trigger select is ignored in timer mode; a random value must not matter
      tsrc = 1'($urandom % 2);
      start = 1'b1;
      repeat (300) begin
         tick = ($urandom % 3) == 0;
         rd_en = $urandom % 2;
         cut_en = 1'($urandom % 2);
         cyc(1);
      end
      {rd_en, tick, start, tsrc} = 4'h0;
      cyc(2);
      mdl_ok = 1'b0;
      chk({15'h0, flag}, 16'h0001, "underflow flag");
      clr();
      done("timer");
      // Cutoff only while enabled and shutdown low
      tick = 1'b1;
      cut_en = 1'b1;
      u_mdt_far_end.set_shutdown(1'b0);
      cyc(8);
      chk({15'h0, toe}, 16'h0000, "cut drive");
      cut_en = 1'b0;
      cyc(3);
      chk({15'h0, toe}, 16'h0001, "cut disabled");
      u_mdt_far_end.set_shutdown(1'b1);
      cut_en = 1'b1;
      cyc(8);
      chk({15'h0, toe}, 16'h0001, "shutdown high");
      done("cutoff");
      // Event counting both ways, reload on overflow and underflow
      set_mode(MDT_EVENT);
      for (int dir = 1; dir >= 0; dir--) begin
         updn = dir[0];
         wr(dir ? 16'hfffd : 16'h0001);
         // Read every cycle, so one read falls on the reload
         e2 = dir ? CNT_ALL_ZEROS : CNT_ALL_ONES;
         sp_on = 1'b1;
         rd_en = 1'b1;
         start = 1'b1;
         repeat (dir ? 3 : 2) u_mdt_far_end.pulse(4);
         rd_en = 1'b0;
         cyc(8);
         chk(n_sp[15:0], 16'h0001, "reload read wrap");
         sp_on = 1'b0;
         rd(v);
         chk(v, dir ? 16'hfffd : 16'h0001, "event reload");
         chk({15'h0, flag}, 16'h0001, "event flag");
         start = 1'b0;
         cyc(1);
         clr();
      end
      done("event");
      // One-shot: selection flag, software start, stop behaviour
      set_mode(MDT_ONESHOT);
      chk({15'h0, flag}, 16'h0001, "one-shot select flag");
      clr();
      chk({15'h0, flag}, 16'h0000, "flag cleared");
      wr(16'h0040);
      start = 1'b1;
      cyc(8);
      chk({15'h0, tout}, 16'h0001, "one-shot running");
      start = 1'b0;
      cyc(1);
      chk({15'h0, tout}, 16'h0000, "stop drops out");
      chk({15'h0, flag}, 16'h0000, "flag not yet");
      cyc(1);
      chk({15'h0, flag}, 16'h0001, "flag one cycle on");
      rd(v);
      chk(v, 16'h0040, "stop reloads");
      clr();
      done("one-shot stop");
      // External trigger, then a retrigger well before zero
      tsrc = 1'b1;
      wr(16'h0030);
      start = 1'b1;
      u_mdt_far_end.pulse(4);
      chk({15'h0, tout}, 16'h0001, "trigger reaches out");
      u_mdt_far_end.pulse(4);
      h = 0;
      while (tout === 1'b1 && h < 200) begin
         cyc(1);
         h++;
      end
      // Without the reload the output would fall about 38 cycles from here
      chk({15'h0, h > 40 && h < 200}, 16'h0001, "retrigger stretch");
      start = 1'b0;
      cyc(3);
      clr();
      done("retrigger");
      // PWM: selection flag, stop while high and while low
      set_mode(MDT_TIMER);
      clr();
      set_mode(MDT_PWM);
      chk({15'h0, flag}, 16'h0001, "pwm select flag");
      clr();
      tsrc = 1'b0;
      wr(16'h0003);
      start = 1'b1;
      cyc(3);
      chk({15'h0, tout}, 16'h0001, "pwm high");
      start = 1'b0;
      cyc(1);
      chk({15'h0, tout}, 16'h0000, "pwm stop high");
      chk({15'h0, flag}, 16'h0001, "pwm stop flag");
      clr();
      start = 1'b1;
      h = 0;
      while (tout !== 1'b1 && h < 20) begin
         cyc(1);
         h++;
      end
      while (tout === 1'b1 && h < 40) begin
         cyc(1);
         h++;
      end
      cyc(2);
      clr();
      start = 1'b0;
      cyc(3);
      chk({15'h0, tout}, 16'h0000, "pwm stop low out");
      chk({15'h0, flag}, 16'h0000, "pwm stop low flag");
      done("pwm");
      close_out();
   end
endmodule
